// ---- rtl/tccg_pkg.sv ----
// constants, role encoding and field layout of the tap changer control gate
// assumes magnitudes arrive as unsigned words already scaled alike
package tccg_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned TAP_W = 6;
    // ------------------------------------------------------------
    // operating roles
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TCCG_ROLE_OFF,
        TCCG_ROLE_SINGLE,
        TCCG_ROLE_MINCIRC,
        TCCG_ROLE_MASTER,
        TCCG_ROLE_SLAVE_CMD,
        TCCG_ROLE_SLAVE_TAP
    } tccg_role_t;
    // ------------------------------------------------------------
    // register map (word addresses on the plain port)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_ROLE = 4'h0;
    localparam logic [3:0] ADDR_HIGH = 4'h1;
    localparam logic [3:0] ADDR_LOW = 4'h2;
    localparam logic [3:0] ADDR_BLOCK = 4'h3;
    localparam logic [3:0] ADDR_OVLD = 4'h4;
    localparam logic [3:0] ADDR_CORR = 4'h5;
    localparam logic [3:0] ADDR_CTRL = 4'h6;
    localparam logic [3:0] ADDR_STAT = 4'h7;
    localparam logic [3:0] ADDR_IRQ_ST = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MSK = 4'h9;
    // control bits
    localparam int unsigned CTRL_MANUAL_BIT = 0;
    localparam int unsigned CTRL_MRAISE_BIT = 1;
    localparam int unsigned CTRL_MLOWER_BIT = 2;
    // event bits
    localparam int unsigned EV_W = 4;
    localparam int unsigned EV_RAISE = 0;
    localparam int unsigned EV_LOWER = 1;
    localparam int unsigned EV_DEENERG = 2;
    localparam int unsigned EV_OVLD = 3;
    // reset values
    localparam logic [DATA_W-1:0] RST_HIGH = 16'hFFFF;
    localparam logic [DATA_W-1:0] RST_LOW = 16'h0000;
    localparam logic [DATA_W-1:0] RST_BLOCK = 16'h0000;
    localparam logic [DATA_W-1:0] RST_OVLD = 16'hFFFF;
    localparam logic [DATA_W-1:0] RST_CORR = 16'h0000;
endpackage

// ---- rtl/tccg_top.sv ----
// decision logic of an on-load tap changer controller
// assumes tick_i, requests and parallel link inputs are on core_clk_i; pins are synchronised
`timescale 1ns/1ps
module tccg_top #(
    parameter bit HAS_PRIMARY_CT = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic [15:0] controlled_side_voltage_i,
    input wire logic [15:0] compensation_current_i,
    input wire logic [15:0] primary_current_max_i,
    input wire logic auto_raise_req_i,
    input wire logic auto_lower_req_i,
    input wire logic manual_request_input_i,
    input wire logic remote_raise_i,
    input wire logic remote_lower_i,
    input wire logic leader_raise_i,
    input wire logic leader_lower_i,
    input wire logic [5:0] leader_tap_i,
    input wire logic [5:0] own_tap_i,
    input wire logic drive_busy_i,
    output logic raise_o,
    output logic lower_o,
    output logic fwd_raise_o,
    output logic fwd_lower_o,
    output logic coop_en_o,
    output logic [15:0] comp_current_o,
    output logic drive_fault_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // settings registers
    // ------------------------------------------------------------
    tccg_pkg::tccg_role_t role_q;
    logic [15:0] high_q, low_q, blk_q, ovld_q, corr_q;
    logic manual_chan_q, mraise_q, mlower_q;
    logic [3:0] irq_st_q, irq_msk_q;
    logic [15:0] rdata_q;

    wire wr_role = reg_wr_i && (reg_addr_i == tccg_pkg::ADDR_ROLE);
    wire wr_high = reg_wr_i && (reg_addr_i == tccg_pkg::ADDR_HIGH);
    wire wr_low = reg_wr_i && (reg_addr_i == tccg_pkg::ADDR_LOW);
    wire wr_blk = reg_wr_i && (reg_addr_i == tccg_pkg::ADDR_BLOCK);
    wire wr_ovld = reg_wr_i && (reg_addr_i == tccg_pkg::ADDR_OVLD);
    wire wr_corr = reg_wr_i && (reg_addr_i == tccg_pkg::ADDR_CORR);
    wire wr_ctrl = reg_wr_i && (reg_addr_i == tccg_pkg::ADDR_CTRL);
    wire wr_ist = reg_wr_i && (reg_addr_i == tccg_pkg::ADDR_IRQ_ST);
    wire wr_msk = reg_wr_i && (reg_addr_i == tccg_pkg::ADDR_IRQ_MSK);
    wire role_ok = (reg_wdata_i[2:0] <= 3'h5);

    // settings write path; illegal role codes are ignored
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            role_q <= tccg_pkg::TCCG_ROLE_OFF;
            high_q <= tccg_pkg::RST_HIGH;
            low_q <= tccg_pkg::RST_LOW;
            blk_q <= tccg_pkg::RST_BLOCK;
            ovld_q <= tccg_pkg::RST_OVLD;
            corr_q <= tccg_pkg::RST_CORR;
        end else begin
            if (wr_role && role_ok) role_q <= tccg_pkg::tccg_role_t'(reg_wdata_i[2:0]);
            if (wr_high) high_q <= reg_wdata_i;
            if (wr_low) low_q <= reg_wdata_i;
            if (wr_blk) blk_q <= reg_wdata_i;
            if (wr_ovld) ovld_q <= reg_wdata_i;
            if (wr_corr) corr_q <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // auto/manual channel
    // ------------------------------------------------------------
    // auto select gate
    wire chan_auto_ok = !reg_wdata_i[tccg_pkg::CTRL_MANUAL_BIT] && !manual_request_input_i;
    wire chan_manual_d = reg_wdata_i[tccg_pkg::CTRL_MANUAL_BIT] ? 1'b1 :
                         (chan_auto_ok ? 1'b0 : manual_chan_q);

    // channel write; manual raise/lower are one-shot software commands
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            manual_chan_q <= 1'b1;
            mraise_q <= 1'b0;
            mlower_q <= 1'b0;
        end else begin
            if (wr_ctrl) manual_chan_q <= chan_manual_d;
            mraise_q <= wr_ctrl && reg_wdata_i[tccg_pkg::CTRL_MRAISE_BIT];
            mlower_q <= wr_ctrl && reg_wdata_i[tccg_pkg::CTRL_MLOWER_BIT];
        end
    end

    wire manual_mode = manual_chan_q || manual_request_input_i;

    // ------------------------------------------------------------
    // limit checks, evaluated on each tick
    // ------------------------------------------------------------
    // correction before compare
    wire [16:0] ucorr_sum = {1'b0, controlled_side_voltage_i} + {corr_q[15], corr_q};
    // a negative correction that underflows leaves the top bit set
    wire corr_neg = corr_q[15] && ucorr_sum[16];
    wire corr_ovf = !corr_q[15] && ucorr_sum[16];
    wire [15:0] ucorr = corr_neg ? 16'h0000 : (corr_ovf ? 16'hFFFF : ucorr_sum[15:0]);

    logic too_high_q, too_low_q, deenerg_q, ovld_hit_q;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            too_high_q <= 1'b1;
            too_low_q <= 1'b1;
            deenerg_q <= 1'b1;
            // without the primary current option this block never asserts
            ovld_hit_q <= HAS_PRIMARY_CT;
        end else if (tick_i) begin
            too_high_q <= (ucorr > high_q);
            too_low_q <= (ucorr < low_q);
            deenerg_q <= (ucorr < blk_q);
            ovld_hit_q <= HAS_PRIMARY_CT && (primary_current_max_i > ovld_q);
        end
    end

    // ------------------------------------------------------------
    // role selection of the raise/lower source
    // ------------------------------------------------------------
    logic src_raise, src_lower, src_coop, src_fwd;
    wire tap_lo = (own_tap_i < leader_tap_i);
    wire tap_hi = (own_tap_i > leader_tap_i);
    always_comb begin
        src_raise = 1'b0;
        src_lower = 1'b0;
        src_coop = 1'b0;
        src_fwd = 1'b0;
        case (role_q)
            tccg_pkg::TCCG_ROLE_OFF: begin
            end
            tccg_pkg::TCCG_ROLE_SINGLE: begin
                src_raise = auto_raise_req_i;
                src_lower = auto_lower_req_i;
            end
            tccg_pkg::TCCG_ROLE_MINCIRC: begin
                src_raise = auto_raise_req_i;
                src_lower = auto_lower_req_i;
                src_coop = 1'b1;
            end
            tccg_pkg::TCCG_ROLE_MASTER: begin
                src_raise = auto_raise_req_i;
                src_lower = auto_lower_req_i;
                src_coop = 1'b1;
                src_fwd = 1'b1;
            end
            tccg_pkg::TCCG_ROLE_SLAVE_CMD: begin
                src_raise = leader_raise_i;
                src_lower = leader_lower_i;
                src_coop = 1'b1;
            end
            tccg_pkg::TCCG_ROLE_SLAVE_TAP: begin
                src_raise = tap_lo;
                src_lower = tap_hi;
                src_coop = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // ------------------------------------------------------------
    // permissions
    // ------------------------------------------------------------
    wire role_on = (role_q != tccg_pkg::TCCG_ROLE_OFF);
    wire auto_ok = role_on && !manual_mode && !deenerg_q && !ovld_hit_q;
    wire a_raise = auto_ok && !too_high_q && src_raise && !src_lower;
    wire a_lower = auto_ok && !too_low_q && src_lower && !src_raise;
    wire man_ok = role_on && manual_mode && !ovld_hit_q;
    wire m_raise_req = remote_raise_i || mraise_q;
    wire m_lower_req = remote_lower_i || mlower_q;
    wire m_raise = man_ok && m_raise_req && !m_lower_req;
    wire m_lower = man_ok && m_lower_req && !m_raise_req;
    wire coop_d = role_on && src_coop && (manual_mode || !deenerg_q);

    // ------------------------------------------------------------
    // command supervisor: sole driver of tap commands
    // ------------------------------------------------------------
    logic raise_q, lower_q, fwd_r_q, fwd_l_q, coop_q, fault_q;
    logic [15:0] comp_q;
    wire want_r = a_raise || m_raise;
    wire want_l = a_lower || m_lower;
    wire issue_r = want_r && !drive_busy_i;
    wire issue_l = want_l && !drive_busy_i;
    // drive busy while no command is pending or registered flags a fault, also during a normal step
    wire fault_d = drive_busy_i && !raise_q && !lower_q && !want_r && !want_l;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            raise_q <= 1'b0;
            lower_q <= 1'b0;
            fwd_r_q <= 1'b0;
            fwd_l_q <= 1'b0;
            coop_q <= 1'b0;
            fault_q <= 1'b0;
            comp_q <= 16'h0000;
        end else begin
            raise_q <= issue_r;
            lower_q <= issue_l;
            fwd_r_q <= issue_r && src_fwd && !manual_mode;
            fwd_l_q <= issue_l && src_fwd && !manual_mode;
            coop_q <= coop_d;
            fault_q <= fault_d;
            comp_q <= compensation_current_i;
        end
    end

    assign raise_o = raise_q;
    assign lower_o = lower_q;
    assign fwd_raise_o = fwd_r_q;
    assign fwd_lower_o = fwd_l_q;
    assign coop_en_o = coop_q;
    assign comp_current_o = comp_q;
    assign drive_fault_o = fault_q;

    // ------------------------------------------------------------
    // interrupts: sticky status, set wins over clear
    // ------------------------------------------------------------
    wire [3:0] ev = {ovld_hit_q, deenerg_q, lower_q, raise_q};
    wire [3:0] clr = wr_ist ? reg_wdata_i[3:0] : 4'h0;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_st_q <= 4'h0;
            irq_msk_q <= 4'h0;
        end else begin
            irq_st_q <= (irq_st_q & ~clr) | ev;
            if (wr_msk) irq_msk_q <= reg_wdata_i[3:0];
        end
    end
    assign irq_o = |(irq_st_q & irq_msk_q);

    // ------------------------------------------------------------
    // read path, data valid one cycle after strobe only
    // ------------------------------------------------------------
    wire [15:0] stat_w = {8'h00, fault_q, coop_q, manual_mode, ovld_hit_q,
                          deenerg_q, too_low_q, too_high_q, 1'b0};
    logic [15:0] rmux;
    always_comb begin
        case (reg_addr_i)
            tccg_pkg::ADDR_ROLE: rmux = {13'h0000, role_q};
            tccg_pkg::ADDR_HIGH: rmux = high_q;
            tccg_pkg::ADDR_LOW: rmux = low_q;
            tccg_pkg::ADDR_BLOCK: rmux = blk_q;
            tccg_pkg::ADDR_OVLD: rmux = ovld_q;
            tccg_pkg::ADDR_CORR: rmux = corr_q;
            tccg_pkg::ADDR_CTRL: rmux = {15'h0000, manual_chan_q};
            tccg_pkg::ADDR_STAT: rmux = stat_w;
            tccg_pkg::ADDR_IRQ_ST: rmux = {12'h000, irq_st_q};
            tccg_pkg::ADDR_IRQ_MSK: rmux = {12'h000, irq_msk_q};
            default: rmux = 16'h0000;
        endcase
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rdata_q <= 16'h0000;
        else rdata_q <= reg_rd_i ? rmux : 16'h0000;
    end
    assign reg_rdata_o = rdata_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_off_quiet;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (role_q == tccg_pkg::TCCG_ROLE_OFF) |=> !raise_o && !lower_o;
    endproperty
    AST_OFF_QUIET: assert property (p_off_quiet) else $error("tap command while off");
    AST_HIGH_NORAISE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (too_high_q && !manual_mode) |=> !raise_o) else $error("raise above limit");
    AST_LOW_NOLOWER: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (too_low_q && !manual_mode) |=> !lower_o) else $error("lower below limit");
    AST_DEENERG_BLOCK: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (deenerg_q && !manual_mode) |=> !raise_o && !lower_o) else $error("auto while dead");
    AST_OVLD_BLOCK: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ovld_hit_q |=> !raise_o && !lower_o) else $error("command in overload");
    AST_NO_CT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !HAS_PRIMARY_CT |-> ##1 !ovld_hit_q) else $error("overload without option");
    AST_COOP_MANUAL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (manual_mode && src_coop && role_on) |=> coop_en_o) else $error("coop lost");
    sequence s_leader_up;
        (role_q == tccg_pkg::TCCG_ROLE_SLAVE_CMD) && leader_raise_i && !leader_lower_i;
    endsequence
    sequence s_clear_path;
        auto_ok && !too_high_q && !drive_busy_i;
    endsequence
    AST_FOLLOW_CMD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (s_leader_up and s_clear_path) |=> raise_o) else $error("leader raise lost");
    AST_TAP_FOLLOW: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ((role_q == tccg_pkg::TCCG_ROLE_SLAVE_TAP) && (own_tap_i == leader_tap_i))
        |=> !raise_o && !lower_o) else $error("step at equal tap");
    AST_FWD_MASTER: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        fwd_raise_o |-> raise_o && $past(role_q) == tccg_pkg::TCCG_ROLE_MASTER)
        else $error("forward not master");
    AST_MAN_BLOCKS_AUTO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (manual_mode && !m_raise_req) |=> !raise_o) else $error("auto in manual");
    AST_CHAN_AUTO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_ctrl && manual_request_input_i && manual_chan_q) |=> manual_chan_q)
        else $error("auto despite req");
    AST_TICK_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !tick_i |=> $stable(too_high_q) && $stable(deenerg_q)) else $error("check off tick");
endmodule

// ---- dv/tccg_drive_model.sv ----
// ----------------------------------------------------------------
// behavioural tap changer drive on the far side of the gate
// ----------------------------------------------------------------
// assumes raise and lower commands are registered levels on core_clk_i
`timescale 1ns/1ps
module tccg_drive_model #(
    parameter logic [5:0] START_TAP = 6'h08
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic raise_i,
    input wire logic lower_i,
    input wire logic slow_i,
    output logic busy_o,
    output logic [5:0] tap_o
);
    logic [3:0] cnt_q;
    logic up_q;
    // one tap step per accepted command, commands ignored while moving
    // busy and tap position reported back to the controller
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_o <= 1'b0;
            cnt_q <= 4'h0;
            up_q <= 1'b0;
            tap_o <= START_TAP;
        end else if (busy_o) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h0) begin
                busy_o <= 1'b0;
                tap_o <= up_q ? tap_o + 6'h01 : tap_o - 6'h01;
            end
        end else if (raise_i ^ lower_i) begin
            busy_o <= 1'b1;
            up_q <= raise_i;
            cnt_q <= slow_i ? 4'h6 : 4'h1; // slow or prompt mechanism
        end
    end
endmodule

// ---- dv/tccg_top_tb.sv ----
// ----------------------------------------------------------------
// self-checking bench for the tap changer control gate
// ----------------------------------------------------------------
// assumes tccg_pkg, tccg_top and tccg_drive_model are compiled first
`timescale 1ns/1ps
module tccg_top_tb;
    logic core_clk_i = 1'b0, rst_n_i = 1'b0, tick_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0000, compensation_current_i = 16'h0000;
    logic [15:0] controlled_side_voltage_i = 16'h1000, primary_current_max_i = 16'h0100;
    logic auto_raise_req_i = 1'b0, auto_lower_req_i = 1'b0, manual_request_input_i = 1'b0;
    logic remote_raise_i = 1'b0, remote_lower_i = 1'b0, leader_raise_i = 1'b0;
    logic leader_lower_i = 1'b0, slow = 1'b0;
    logic [5:0] leader_tap_i = 6'h08, own_tap_i;
    logic [15:0] reg_rdata_o, comp_current_o;
    logic drive_busy_i, raise_o, lower_o, fwd_raise_o, fwd_lower_o, coop_en_o;
    logic drive_fault_o, irq_o, nc_raise;
    int failures = 0, total_checks = 0;

    always #20 core_clk_i = ~core_clk_i;

    // ----------------------------------------------------------------
    // design, variant without primary current option, drive model
    // ----------------------------------------------------------------
    tccg_top uut (.core_clk_i, .rst_n_i, .tick_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .controlled_side_voltage_i, .compensation_current_i,
        .primary_current_max_i, .auto_raise_req_i, .auto_lower_req_i, .manual_request_input_i,
        .remote_raise_i, .remote_lower_i, .leader_raise_i, .leader_lower_i, .leader_tap_i,
        .own_tap_i, .drive_busy_i, .raise_o, .lower_o, .fwd_raise_o, .fwd_lower_o, .coop_en_o,
        .comp_current_o, .drive_fault_o, .irq_o);
    tccg_top #(.HAS_PRIMARY_CT(1'b0)) uut_noct (.core_clk_i, .rst_n_i, .tick_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o(), .controlled_side_voltage_i,
        .compensation_current_i, .primary_current_max_i, .auto_raise_req_i, .auto_lower_req_i,
        .manual_request_input_i, .remote_raise_i, .remote_lower_i, .leader_raise_i,
        .leader_lower_i, .leader_tap_i, .own_tap_i, .drive_busy_i, .raise_o(nc_raise),
        .lower_o(), .fwd_raise_o(), .fwd_lower_o(), .coop_en_o(), .comp_current_o(),
        .drive_fault_o(), .irq_o());
    tccg_drive_model drive (.core_clk_i, .rst_n_i, .raise_i(raise_o), .lower_i(lower_o),
        .slow_i(slow), .busy_o(drive_busy_i), .tap_o(own_tap_i));

    // ----------------------------------------------------------------
    // compare, bus and stimulus tasks
    // ----------------------------------------------------------------
    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m,
                      input string name);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk16(name, exp, reg_rdata_o & m);
    endtask

    // checks latch on the edge that sees the tick
    task automatic eval(input logic [15:0] v, input logic [15:0] i);
        @(posedge core_clk_i);
        controlled_side_voltage_i <= v;
        primary_current_max_i <= i;
        tick_i <= 1'b1;
        @(posedge core_clk_i);
        tick_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    // req: auto r/l, remote r/l, leader r/l; exp: raise, lower, fwd r/l, raise of variant
    task automatic cmd(input logic [5:0] req, input logic [4:0] exp, input string name);
        int n;
        n = 0;
        @(posedge core_clk_i);
        while (drive_busy_i !== 1'b0 && n < 40) begin
            @(posedge core_clk_i);
            n++;
        end
        {auto_raise_req_i, auto_lower_req_i, remote_raise_i, remote_lower_i, leader_raise_i,
         leader_lower_i} <= req;
        @(posedge core_clk_i);
        #1 chk16(name, {11'h000, exp}, {11'h000, raise_o, lower_o, fwd_raise_o, fwd_lower_o,
                                        nc_raise});
        @(posedge core_clk_i);
        {auto_raise_req_i, auto_lower_req_i, remote_raise_i, remote_lower_i, leader_raise_i,
         leader_lower_i} <= 6'h00;
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog well beyond the length of the sequence
    initial begin
        #800000;
        failures++;
        conclude();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        int n;
        repeat (3) @(posedge core_clk_i);
        chk16("outputs in reset", 16'h0000, {10'h000, raise_o, lower_o, fwd_raise_o,
              fwd_lower_o, coop_en_o, irq_o});
        rst_n_i <= 1'b1;
        rd(tccg_pkg::ADDR_ROLE, 16'h0000, 16'hFFFF, "role reset");
        wr(tccg_pkg::ADDR_ROLE, 16'h0007);
        rd(tccg_pkg::ADDR_ROLE, 16'h0000, 16'hFFFF, "role illegal");
        rd(tccg_pkg::ADDR_HIGH, tccg_pkg::RST_HIGH, 16'hFFFF, "high reset");
        rd(tccg_pkg::ADDR_LOW, tccg_pkg::RST_LOW, 16'hFFFF, "low reset");
        rd(tccg_pkg::ADDR_BLOCK, tccg_pkg::RST_BLOCK, 16'hFFFF, "block reset");
        rd(tccg_pkg::ADDR_OVLD, tccg_pkg::RST_OVLD, 16'hFFFF, "overload reset");
        rd(tccg_pkg::ADDR_CORR, tccg_pkg::RST_CORR, 16'hFFFF, "corr reset");
        rd(4'hA, 16'h0000, 16'hFFFF, "unmapped read");
        rd(tccg_pkg::ADDR_STAT, 16'h003E, 16'h003E, "status before tick");
        rd(tccg_pkg::ADDR_IRQ_ST, 16'h000C, 16'h000F, "irq after reset");
        wr(tccg_pkg::ADDR_HIGH, 16'h1200);
        wr(tccg_pkg::ADDR_LOW, 16'h0E00);
        wr(tccg_pkg::ADDR_BLOCK, 16'h0800);
        wr(tccg_pkg::ADDR_OVLD, 16'h0500);
        eval(16'h1000, 16'h0100);
        rd(tccg_pkg::ADDR_STAT, 16'h0020, 16'h003E, "status normal");
        wr(tccg_pkg::ADDR_IRQ_ST, 16'h000F);
        rd(tccg_pkg::ADDR_IRQ_ST, 16'h0000, 16'h000F, "irq cleared");
        // off role issues nothing for an automatic raise request
        cmd(6'b100000, 5'b00000, "off auto raise");
        wr(tccg_pkg::ADDR_CTRL, 16'h0000);
        wr(tccg_pkg::ADDR_ROLE, 16'h0001);
        rd(tccg_pkg::ADDR_STAT, 16'h0000, 16'h0020, "auto selected");
        cmd(6'b100000, 5'b10001, "single raise");
        cmd(6'b010000, 5'b01000, "single lower");
        cmd(6'b110000, 5'b00000, "both refused");
        rd(tccg_pkg::ADDR_IRQ_ST, 16'h0003, 16'h000F, "command events");
        #1 chk16("irq masked", 16'h0000, {15'h0000, irq_o});
        wr(tccg_pkg::ADDR_IRQ_MSK, 16'h0001);
        #1 chk16("irq unmasked", 16'h0001, {15'h0000, irq_o});
        wr(tccg_pkg::ADDR_IRQ_ST, 16'h0001);
        #1 chk16("irq after clear", 16'h0000, {15'h0000, irq_o});
        wr(tccg_pkg::ADDR_IRQ_MSK, 16'h0000);
        @(posedge core_clk_i);
        compensation_current_i <= 16'h0ABC;
        @(posedge core_clk_i);
        #1 chk16("comp current", 16'h0ABC, comp_current_o);
        // voltage limits gate automatic commands
        eval(16'h1300, 16'h0100);
        cmd(6'b100000, 5'b00000, "raise above high");
        cmd(6'b010000, 5'b01000, "lower above high");
        eval(16'h0D00, 16'h0100);
        cmd(6'b100000, 5'b10001, "raise below low");
        cmd(6'b010000, 5'b00000, "lower below low");
        rd(tccg_pkg::ADDR_STAT, 16'h0004, 16'h001E, "status too low");
        wr(tccg_pkg::ADDR_CORR, 16'h0100);
        eval(16'h1150, 16'h0100);
        cmd(6'b100000, 5'b00000, "raise corrected up");
        wr(tccg_pkg::ADDR_CORR, 16'hFF00);
        eval(16'h1250, 16'h0100);
        cmd(6'b100000, 5'b10001, "raise corrected down");
        wr(tccg_pkg::ADDR_CORR, 16'h0000);
        // de-energised: automatic off, cooperation kept only in manual
        wr(tccg_pkg::ADDR_ROLE, 16'h0002);
        eval(16'h1000, 16'h0100);
        #1 chk16("coop normal", 16'h0001, {15'h0000, coop_en_o});
        eval(16'h0700, 16'h0100);
        cmd(6'b100000, 5'b00000, "raise deenerg");
        cmd(6'b010000, 5'b00000, "lower deenerg");
        #1 chk16("coop auto deenerg", 16'h0000, {15'h0000, coop_en_o});
        // manual select with a one-shot software raise
        wr(tccg_pkg::ADDR_CTRL, 16'h0003);
        @(posedge core_clk_i);
        #1 chk16("soft raise", 16'h0001, {15'h0000, raise_o});
        repeat (4) @(posedge core_clk_i);
        cmd(6'b001000, 5'b10001, "manual raise deenerg");
        #1 chk16("coop manual deenerg", 16'h0001, {15'h0000, coop_en_o});
        rd(tccg_pkg::ADDR_IRQ_ST, 16'h0004, 16'h0004, "deenerg event");
        // overload blocks manual and automatic where the option is fitted
        eval(16'h1000, 16'h0600);
        cmd(6'b001000, 5'b00001, "manual overload");
        wr(tccg_pkg::ADDR_CTRL, 16'h0000);
        cmd(6'b100000, 5'b00001, "auto overload");
        rd(tccg_pkg::ADDR_STAT, 16'h0010, 16'h0010, "status overload");
        eval(16'h1000, 16'h0100);
        // manual request input overrides the channel
        wr(tccg_pkg::ADDR_CTRL, 16'h0001);
        manual_request_input_i <= 1'b1;
        wr(tccg_pkg::ADDR_CTRL, 16'h0000);
        rd(tccg_pkg::ADDR_STAT, 16'h0020, 16'h0020, "manual forced");
        cmd(6'b100000, 5'b00000, "auto in manual");
        manual_request_input_i <= 1'b0;
        rd(tccg_pkg::ADDR_STAT, 16'h0020, 16'h0020, "manual kept");
        wr(tccg_pkg::ADDR_CTRL, 16'h0000);
        rd(tccg_pkg::ADDR_STAT, 16'h0000, 16'h0020, "auto again");
        // leading and following roles
        wr(tccg_pkg::ADDR_ROLE, 16'h0003);
        cmd(6'b100000, 5'b10101, "master raise");
        cmd(6'b010000, 5'b01010, "master lower");
        wr(tccg_pkg::ADDR_CTRL, 16'h0001);
        cmd(6'b001000, 5'b10001, "master manual");
        wr(tccg_pkg::ADDR_CTRL, 16'h0000);
        wr(tccg_pkg::ADDR_ROLE, 16'h0004);
        cmd(6'b000010, 5'b10001, "follow raise");
        cmd(6'b000001, 5'b01000, "follow lower");
        wr(tccg_pkg::ADDR_ROLE, 16'h0005);
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk_i);
            leader_tap_i <= (k == 0) ? 6'h0A : 6'h05;
            slow <= (k == 0);
            n = 0;
            @(posedge core_clk_i);
            while (!(own_tap_i === leader_tap_i && drive_busy_i === 1'b0) && n < 300) begin
                @(posedge core_clk_i);
                n++;
            end
            repeat (4) @(posedge core_clk_i);
            #1 chk16("tap follow", {10'h000, leader_tap_i}, {10'h000, own_tap_i});
            chk16("tap idle", 16'h0000, {13'h0000, raise_o, lower_o, drive_fault_o});
        end
        conclude();
    end
endmodule
